// >>> src/eirq_pkg.sv
// Behaviour
// R01: Bits 10..19 enable the ten extended interrupts
// R02: Bits 11..19 enable irq 7-13, 17, 18
// R03: Bits 20..29 show nested-context mask state
// R04: Bits 21..29 follow bit 20 in order
// R05: Register is 32-bit RW, top two reserved
// R06: Status push clears mode bits set in mask
// R07: Clearing on interrupt entry and push instruction
// R08: Second element enable mask bit resets to one
// R09: Latch bits set by routed interrupt sources
// R10: Software leaves nest pointer bits alone
// R11: Interrupt requested only when latched and enabled
package eirq_pkg;
  localparam int unsigned NUM_IRQ        = 10;           // Extended interrupt count
  localparam int unsigned LATCH_LSB      = 0;            // Latch field base
  localparam int unsigned ENABLE_LSB     = 10;           // Enable field base
  localparam int unsigned POINTER_LSB    = 20;           // Nest pointer field base
  localparam int unsigned MODE_WIDTH     = 32;           // Mode-control register width
  localparam int unsigned SEC_ELEM_BIT   = 21;           // Second element enable position
  localparam logic [31:0] FIELD_MASK     = 32'h3FFFFFFF; // Implemented bits
  localparam logic [31:0] LATCH_RESET    = 32'h00000000; // Extended register reset
  localparam logic [31:0] MODE_CLEAR_ON_PUSH_MASK_RESET    = 32'h00200000; // Mode mask reset, second element set
  localparam logic [3:0]  ADDR_LATCH     = 4'h0;         // Extended register offset
  localparam logic [3:0]  ADDR_MODE_CLEAR_ON_PUSH_MASK     = 4'h4;         // Mode mask offset
  localparam logic [3:0]  ADDR_MODE      = 4'h8;         // Mode-control offset
  localparam logic [3:0]  ADDR_REQ       = 4'hC;         // Pending request view offset
  localparam logic [1:0]  RESP_OKAY      = 2'h0;         // AXI OKAY
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;         // AXI SLVERR
  typedef struct packed {
    logic        entry_push;  // Push on interrupt entry
    logic        instr_push;  // Explicit status push instruction
    logic        nest_valid;  // Nesting logic writes pointer bits
    logic [9:0]  nest_value;  // New pointer bits
  } eirq_core_type;
endpackage

// >>> src/eirq_reg_word.sv
`timescale 1ns/1ps
// One register word with per-bit write enable and reset value
module eirq_reg_word #(
  parameter int unsigned W     = 32,       // Word width
  parameter logic [31:0] RESET = 32'h0     // Reset value
) (
  input  wire logic         sys_clk,       // Core clock
  input  wire logic         rst_b,         // Async reset, low
  input  wire logic         clk_en,        // Freeze when low
  input  wire logic [W-1:0] wr_bits,       // Bits to load
  input  wire logic [W-1:0] wr_data,       // Load data
  output logic      [W-1:0] rd_q           // Stored value
);
  initial
  begin
    if (W < 1 || W > 32) $error("eirq_reg_word: bad width");
  end
  // Bitwise load keeps each bit's own enable
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      rd_q <= RESET[W-1:0];
    else if (clk_en)
      rd_q <= (rd_q & ~wr_bits) | (wr_data & wr_bits);
  end
endmodule // eirq_reg_word

// >>> src/eirq_latch_mask.sv
`timescale 1ns/1ps
module eirq_latch_mask (
  input  wire logic                 sys_clk,     // Core clock, 200 MHz
  input  wire logic                 rst_b,       // Async reset, low
  input  wire logic                 clk_en,      // Freeze all state when low
  input  wire logic [9:0]           irq_src,     // Routed source pulses
  input  wire eirq_pkg::eirq_core_type core_evt, // Sequencer events
  output logic      [9:0]           irq_req_q,   // Latched and enabled
  output logic      [31:0]          mode_q,      // Primary mode control
  input  wire logic [3:0]           s_axi_awaddr,  // Write address
  input  wire logic                 s_axi_awvalid, // Write address valid
  output logic                      s_axi_awready, // Write address ready
  input  wire logic [31:0]          s_axi_wdata,   // Write data
  input  wire logic [3:0]           s_axi_wstrb,   // Byte enables
  input  wire logic                 s_axi_wvalid,  // Write data valid
  output logic                      s_axi_wready,  // Write data ready
  output logic [1:0]                s_axi_bresp,   // Write response
  output logic                      s_axi_bvalid,  // Write response valid
  input  wire logic                 s_axi_bready,  // Write response ready
  input  wire logic [3:0]           s_axi_araddr,  // Read address
  input  wire logic                 s_axi_arvalid, // Read address valid
  output logic                      s_axi_arready, // Read address ready
  output logic [31:0]               s_axi_rdata,   // Read data
  output logic [1:0]                s_axi_rresp,   // Read response
  output logic                      s_axi_rvalid,  // Read valid
  input  wire logic                 s_axi_rready   // Read ready
);
  localparam int unsigned N = eirq_pkg::NUM_IRQ;
  localparam int unsigned LL = eirq_pkg::LATCH_LSB;
  localparam int unsigned EL = eirq_pkg::ENABLE_LSB;
  localparam int unsigned PL = eirq_pkg::POINTER_LSB;
  initial
  begin
    if (eirq_pkg::SEC_ELEM_BIT >= eirq_pkg::MODE_WIDTH) $error("eirq_latch_mask: bad mode bit");
  end

  // Strobe mask from byte enables
  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  logic [31:0] latch_q;          // Extended latch/enable/pointer
  logic [31:0] mode_clear_on_push_mask_q;          // Mode clear mask
  logic        aw_held_q;        // Address taken
  logic        w_held_q;         // Data taken
  logic [3:0]  awaddr_q;         // Held write address
  logic [31:0] wdata_q;          // Held write data
  logic [3:0]  wstrb_q;          // Held strobes

  // Write channel acceptance, either order
  wire aw_fire = s_axi_awvalid && s_axi_awready;
  wire w_fire  = s_axi_wvalid && s_axi_wready;
  wire wr_go   = aw_held_q && w_held_q && !s_axi_bvalid;
  wire [31:0] wr_mask  = strb_mask(wstrb_q) & eirq_pkg::FIELD_MASK; // [R05]
  wire sel_latch = wr_go && (awaddr_q == eirq_pkg::ADDR_LATCH);
  wire sel_mode_clear_on_push_mask = wr_go && (awaddr_q == eirq_pkg::ADDR_MODE_CLEAR_ON_PUSH_MASK);
  wire sel_mode  = wr_go && (awaddr_q == eirq_pkg::ADDR_MODE);
  wire wr_known  = sel_latch || sel_mode_clear_on_push_mask || sel_mode || (awaddr_q == eirq_pkg::ADDR_REQ);

  // Status push from either cause clears masked mode bits
  wire push_any = core_evt.entry_push || core_evt.instr_push; // [R07]

  // Latch field: hardware set beats software clear
  wire [9:0] lat_cur  = latch_q[LL +: N];
  wire [9:0] lat_sw   = sel_latch ? ((lat_cur & ~wr_mask[LL +: N]) | (wdata_q[LL +: N] & wr_mask[LL +: N]))
                                  : lat_cur;
  wire [9:0] lat_next = lat_sw | irq_src; // [R09]
  // Enable field software owned
  wire [9:0] en_next  = sel_latch ? ((latch_q[EL +: N] & ~wr_mask[EL +: N]) | (wdata_q[EL +: N] & wr_mask[EL +: N]))
                                  : latch_q[EL +: N]; // [R01] [R02]
  // Pointer field: nesting logic owns it; software writes still land, at its own risk
  wire [9:0] ptr_sw   = sel_latch ? ((latch_q[PL +: N] & ~wr_mask[PL +: N]) | (wdata_q[PL +: N] & wr_mask[PL +: N]))
                                  : latch_q[PL +: N]; // [R10]
  wire [9:0] ptr_next = core_evt.nest_valid ? core_evt.nest_value : ptr_sw; // [R03] [R04]
  wire [31:0] latch_d = {2'b00, ptr_next, en_next, lat_next}; // [R05]

  // Mode register: push clear wins over software write
  wire [31:0] mode_sw = sel_mode ? ((mode_q & ~strb_mask(wstrb_q)) | (wdata_q & strb_mask(wstrb_q))) : mode_q;
  wire [31:0] mode_d  = push_any ? (mode_sw & ~mode_clear_on_push_mask_q) : mode_sw; // [R06]
  wire [31:0] mm_bits = sel_mode_clear_on_push_mask ? strb_mask(wstrb_q) : 32'h00000000;

  eirq_reg_word #(
    .W     (32),
    .RESET (eirq_pkg::MODE_CLEAR_ON_PUSH_MASK_RESET)      // [R08]
  ) u_mode_clear_on_push_mask (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .clk_en  (clk_en),
    .wr_bits (mm_bits),
    .wr_data (wdata_q),
    .rd_q    (mode_clear_on_push_mask_q)
  );

  // Register state
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      latch_q   <= eirq_pkg::LATCH_RESET;
      mode_q    <= 32'h00000000;
      irq_req_q <= 10'h000;
    end
    else if (clk_en)
    begin
      latch_q   <= latch_d;
      mode_q    <= mode_d;
      irq_req_q <= lat_next & en_next; // [R11]
    end
  end

  // Write handshake state
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= 4'h0;
      wdata_q   <= 32'h00000000;
      wstrb_q   <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= eirq_pkg::RESP_OKAY;
    end
    else if (clk_en)
    begin
      if (aw_fire)
      begin
        aw_held_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (w_fire)
      begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_held_q    <= 1'b0;
        w_held_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? eirq_pkg::RESP_OKAY : eirq_pkg::RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Ready is registered; low while a word is held
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end
    else if (clk_en)
    begin
      s_axi_awready <= !aw_held_q && !aw_fire && !wr_go;
      s_axi_wready  <= !w_held_q && !w_fire && !wr_go;
    end
  end

  // Read path, one outstanding
  wire [31:0] rd_word = (s_axi_araddr == eirq_pkg::ADDR_LATCH) ? latch_q :
                        (s_axi_araddr == eirq_pkg::ADDR_MODE_CLEAR_ON_PUSH_MASK) ? mode_clear_on_push_mask_q :
                        (s_axi_araddr == eirq_pkg::ADDR_MODE)  ? mode_q  :
                        (s_axi_araddr == eirq_pkg::ADDR_REQ)   ? {22'h000000, irq_req_q} : 32'h00000000;
  wire rd_known = (s_axi_araddr == eirq_pkg::ADDR_LATCH) || (s_axi_araddr == eirq_pkg::ADDR_MODE_CLEAR_ON_PUSH_MASK) ||
                  (s_axi_araddr == eirq_pkg::ADDR_MODE)  || (s_axi_araddr == eirq_pkg::ADDR_REQ);
  wire ar_fire = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= eirq_pkg::RESP_OKAY;
    end
    else if (clk_en)
    begin
      s_axi_arready <= !s_axi_rvalid && !ar_fire && !s_axi_arready;
      if (ar_fire)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_known ? eirq_pkg::RESP_OKAY : eirq_pkg::RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // Checks
  sequence s_src_seen(int b);
    clk_en && irq_src[b];
  endsequence
  a_reserved_zero: assert property (@(posedge sys_clk) disable iff (!rst_b) latch_q[31:30] == 2'b00) // [R05]
    else $error("reserved bits set");
  a_src_latches: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_src_seen(0) |=> latch_q[LL]) // [R09]
    else $error("source not latched");
  a_req_gating: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en |=> irq_req_q == ($past(lat_next) & $past(en_next))) // [R11]
    else $error("request not latch and enable");
  a_req_needs_en: assert property (@(posedge sys_clk) disable iff (!rst_b)
    irq_req_q != 10'h000 |-> (irq_req_q & ~latch_q[EL +: N]) == 10'h000 || $past(sel_latch)) // [R01]
    else $error("request while masked");
  a_push_clears: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && push_any |=> (mode_q & $past(mode_clear_on_push_mask_q)) == 32'h00000000) // [R06]
    else $error("mode bits not cleared");
  a_instr_push: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && core_evt.instr_push && mode_clear_on_push_mask_q[eirq_pkg::SEC_ELEM_BIT] |=> !mode_q[eirq_pkg::SEC_ELEM_BIT]) // [R07]
    else $error("instruction push missed");
  a_nest_load: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && core_evt.nest_valid |=> latch_q[PL +: N] == $past(core_evt.nest_value)) // [R03]
    else $error("pointer not loaded");
  a_ptr_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && !core_evt.nest_valid && !sel_latch |=> $stable(latch_q[PL +: N])) // [R04]
    else $error("pointer moved");
  a_bresp_once: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && wr_go |=> s_axi_bvalid && !aw_held_q) // [R05]
    else $error("no write response");

  // Clock enable low freezes every register of the block
  a_freeze_hold: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R05]
    !clk_en |=> $stable(latch_q) && $stable(mode_q) && $stable(mode_clear_on_push_mask_q))
    else $error("state moved while frozen");
  // Outputs freeze with the state, so a stalled core sees no new answer
  a_freeze_outs: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R11]
    !clk_en |=> $stable(irq_req_q) && $stable(s_axi_bvalid) && $stable(s_axi_rvalid))
    else $error("outputs moved while frozen");

  // Push steps: each cause seen while the clock is enabled
  sequence s_entry_push;
    clk_en && core_evt.entry_push;
  endsequence
  sequence s_instr_push;
    clk_en && core_evt.instr_push;
  endsequence
  // Entry into service clears the second element enable when masked
  a_entry_push: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R07]
    (s_entry_push ##0 mode_clear_on_push_mask_q[eirq_pkg::SEC_ELEM_BIT]) |=> !mode_q[eirq_pkg::SEC_ELEM_BIT])
    else $error("entry push missed");
  // Instruction push clears any masked bit, not only the default one
  a_instr_any: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R07]
    s_instr_push |=> (mode_q & $past(mode_clear_on_push_mask_q)) == 32'h00000000)
    else $error("instruction push left bits");
  // Bits outside the mask survive a push untouched
  a_push_keeps: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R06]
    clk_en && push_any && !sel_mode |=> (mode_q & ~$past(mode_clear_on_push_mask_q)) == ($past(mode_q) & ~$past(mode_clear_on_push_mask_q)))
    else $error("unmasked mode bit cleared");
  // Without a push or a write the mode word holds
  a_mode_hold: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R06]
    clk_en && !push_any && !sel_mode |=> $stable(mode_q))
    else $error("mode moved without cause");

  // Latch bits only move on a source or a software write
  a_latch_holds: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R09]
    clk_en && !sel_latch && irq_src == 10'h000 |=> $stable(latch_q[LL +: N]))
    else $error("latch moved without cause");
  // Enable field belongs to software alone
  a_enable_hold: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R02]
    clk_en && !sel_latch |=> $stable(latch_q[EL +: N]))
    else $error("enable moved without write");

  // Write response: both words held, answer on the next edge
  sequence s_both_held;
    clk_en && aw_held_q && w_held_q && !s_axi_bvalid;
  endsequence
  a_wr_answer: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R05]
    s_both_held |=> s_axi_bvalid && !w_held_q)
    else $error("write not answered");
  // A response stands until the master takes it
  a_bvalid_stands: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R05]
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");

  // Read answer one edge after the address is taken
  sequence s_rd_taken;
    clk_en && ar_fire;
  endsequence
  a_rd_answer: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R05]
    s_rd_taken |=> s_axi_rvalid)
    else $error("read not answered");
  // Unmapped reads are refused with an error code
  a_rd_unmapped: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R05]
    (s_rd_taken ##0 !rd_known) |=> s_axi_rresp == eirq_pkg::RESP_SLVERR)
    else $error("unmapped read accepted");
  // Read data stand with valid until taken
  a_rvalid_stands: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R05]
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");

  // Per-line gating, one checker set for each extended interrupt
  genvar gi;
  generate
    for (gi = 0; gi < N; gi = gi + 1)
    begin : g_req_chk
      // Masked line never reaches the sequencer
      a_mask_blocks: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R01]
        clk_en && !en_next[gi] |=> !irq_req_q[gi])
        else $error("masked line requested");
      // Latched and enabled line is requested on the next edge
      a_req_raises: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R11]
        clk_en && lat_next[gi] && en_next[gi] |=> irq_req_q[gi])
        else $error("enabled line not requested");
      // Each pointer bit takes its own line's nesting value
      a_ptr_bit: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R04]
        clk_en && core_evt.nest_valid |=> latch_q[PL + gi] == $past(core_evt.nest_value[gi]))
        else $error("pointer bit misplaced");
    end
  endgenerate
endmodule // eirq_latch_mask

// >>> sim/eirq_src_model.sv
`timescale 1ns/1ps
// Far side: routed peripheral sources and sequencer events
module eirq_src_model (
  input  wire logic               sys_clk,  // Core clock
  output logic [9:0]              irq_src,  // Routed source lines
  output eirq_pkg::eirq_core_type core_evt  // Sequencer events
);
  // Idle low at time zero
  initial
  begin
    irq_src = 10'h000;
    core_evt = '0;
  end
  // One-cycle pulse on a source, then idle
  task automatic pulse_irq(input int idx);
    @(posedge sys_clk) irq_src[idx] <= 1'b1;
    @(posedge sys_clk) irq_src <= 10'h000;
  endtask
  // Kind 0 is interrupt entry, kind 1 the push instruction
  task automatic push(input bit kind);
    @(posedge sys_clk)
    begin
      core_evt.entry_push <= !kind;
      core_evt.instr_push <= kind;
    end
    @(posedge sys_clk) core_evt <= '0;
  endtask
  // Nesting logic owns the pointer bits
  task automatic load_nest(input logic [9:0] v);
    @(posedge sys_clk)
    begin
      core_evt.nest_valid <= 1'b1;
      core_evt.nest_value <= v;
    end
    @(posedge sys_clk) core_evt <= '0;
  endtask
endmodule // eirq_src_model

// >>> sim/tb_extended_irq_latch_mask_regs.sv
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end
module tb_extended_irq_latch_mask_regs;
  logic        sys_clk = 1'b0;       // 200 MHz clock
  logic        rst_b = 1'b0;         // Reset, low
  logic        clk_en = 1'b1;        // Clock enable
  logic [9:0]  irq_src;              // From model
  eirq_pkg::eirq_core_type core_evt; // From model
  logic [9:0]  irq_req_q;            // Requests out
  logic [31:0] mode_q;               // Mode control out
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [3:0]  wstrb = 4'hF;         // Write byte enables
  logic [1:0]  bresp, rresp, rsp;
  int          n_fail = 0, samples_checked = 0, cyc = 0;
  always #2.5 sys_clk = ~sys_clk;
  eirq_latch_mask eirq_latch_mask_i (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en), .irq_src(irq_src),
    .core_evt(core_evt), .irq_req_q(irq_req_q), .mode_q(mode_q), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  eirq_src_model eirq_src_model_i (.sys_clk(sys_clk), .irq_src(irq_src), .core_evt(core_evt));
  // Verdict, reached once
  task automatic close_out();
    $display("mismatches %0d comparisons %0d", n_fail, samples_checked);
    if (n_fail == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Hang guard, well above the expected run
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_fail++;
      close_out();
    end
  end
  // AXI write: both channels offered together, each dropped when taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask
  // AXI read: data and response taken at the rvalid edge
  task automatic rdw(input logic [3:0] a);
    @(posedge sys_clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata; rsp = rresp; rready <= 1'b0;
  endtask
  // Reset values of all three registers
  task automatic t_reset();
    rdw(eirq_pkg::ADDR_LATCH); `CHK(rd, eirq_pkg::LATCH_RESET)
    rdw(eirq_pkg::ADDR_MODE_CLEAR_ON_PUSH_MASK); `CHK(rd, eirq_pkg::MODE_CLEAR_ON_PUSH_MASK_RESET)
    rdw(eirq_pkg::ADDR_MODE); `CHK(rd, 32'h00000000)
    rdw(4'h2); `CHK(rsp, eirq_pkg::RESP_SLVERR)
  endtask
  // Each source latches and requests while enabled; masked source 4 latches but does not request; reserved bits stay zero
  task automatic t_latch();
    wr(eirq_pkg::ADDR_LATCH, 32'hC00FFC00);
    rdw(eirq_pkg::ADDR_LATCH); `CHK(rd, 32'h000FFC00)
    for (int i = 0; i < 10; i++)
    begin
      eirq_src_model_i.pulse_irq(i);
      repeat (3) @(posedge sys_clk);
      `CHK(irq_req_q, 10'h001 << i)
      wr(eirq_pkg::ADDR_LATCH, 32'h000FFC00);
    end
    wr(eirq_pkg::ADDR_LATCH, 32'h000FFC00 & ~(32'h1 << 14));
    eirq_src_model_i.pulse_irq(4);
    repeat (3) @(posedge sys_clk);
    `CHK(irq_req_q, 10'h000)
    rdw(eirq_pkg::ADDR_LATCH); `CHK(rd, 32'h000FBC10)
    wr(eirq_pkg::ADDR_LATCH, 32'h000FFC10);
    repeat (2) @(posedge sys_clk);
    `CHK(irq_req_q, 10'h010)
    wr(eirq_pkg::ADDR_LATCH, 32'h000FFC00);
  endtask
  // Clock enable low: a source pulse must not land
  task automatic t_freeze();
    @(posedge sys_clk);
    clk_en <= 1'b0;
    eirq_src_model_i.pulse_irq(2);
    repeat (2) @(posedge sys_clk);
    `CHK(irq_req_q, 10'h000)
    clk_en <= 1'b1;
    rdw(eirq_pkg::ADDR_LATCH); `CHK(rd, 32'h000FFC00)
  endtask
  // Nesting logic fills the pointer field in order
  task automatic t_nest();
    eirq_src_model_i.load_nest(10'h2A5);
    rdw(eirq_pkg::ADDR_LATCH); `CHK(rd, 32'h2A5FFC00)
  endtask
  // Push by entry, then by instruction with a new mask
  task automatic t_push();
    wr(eirq_pkg::ADDR_MODE, 32'hFFFFFFFF);
    eirq_src_model_i.push(1'b0);
    repeat (2) @(posedge sys_clk);
    `CHK(mode_q, 32'hFFDFFFFF)
    wr(eirq_pkg::ADDR_MODE_CLEAR_ON_PUSH_MASK, 32'h8000000F);
    eirq_src_model_i.push(1'b1);
    rdw(eirq_pkg::ADDR_MODE); `CHK(rd, 32'h7FDFFFF0)
    wstrb <= 4'h1;
    wr(eirq_pkg::ADDR_MODE, 32'h00000000);
    wstrb <= 4'hF;
    rdw(eirq_pkg::ADDR_MODE); `CHK(rd, 32'h7FDFFF00)
  endtask
  // Main sequence
  initial
  begin
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge sys_clk);
    t_reset();
    t_latch();
    t_freeze();
    t_nest();
    t_push();
    close_out();
  end
endmodule // tb_extended_irq_latch_mask_regs
